// ===== rtl/iat_core.v
// second own address matcher and SCL/SDA timing generator with register port
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "iat_map.vh"
module iat_core (
	// clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// register port
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	// address match request from the slave receiver
	input wire addr_valid_i,
	input wire [6:0] rx_addr_i,
	output reg match_valid_o,
	output reg match_o,
	output reg ack_o,
	// data bit to send from the master engine
	input wire tx_bit_i,
	// bus pins, open drain: enable high pulls low
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe_o,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	// status to the controller
	output reg peripheral_enable_o,
	output reg bit_done_o
);
	// ************************************************************
	// registers
	// ************************************************************
	reg [31:0] second_own_address;
	reg [31:0] bus_timing_config;
	reg [1:0] ctrl;
	reg [7:0] cycles_done;
	reg [2:0] state;
	wire peripheral_enable = ctrl[`IAT_CTRL_PE];
	wire second_address_enable = second_own_address[`IAT_F_EN];
	wire [2:0] second_address_mask =
		second_own_address[`IAT_F_MSK_HI:`IAT_F_MSK_LO];
	wire [7:0] scl_low_count =
		bus_timing_config[`IAT_F_SCL_LOW_COUNT_HI:`IAT_F_SCL_LOW_COUNT_LO];
	wire [7:0] scl_high_count =
		bus_timing_config[`IAT_F_SCL_HIGH_COUNT_HI:`IAT_F_SCL_HIGH_COUNT_LO];
	wire [3:0] data_hold_count =
		bus_timing_config[`IAT_F_HOLD_HI:`IAT_F_HOLD_LO];
	wire [3:0] data_setup_count =
		bus_timing_config[`IAT_F_SETUP_HI:`IAT_F_SETUP_LO];
	wire [3:0] timing_prescaler =
		bus_timing_config[`IAT_F_PSC_HI:`IAT_F_PSC_LO];

	// ************************************************************
	// register write
	// ************************************************************
	// hardware does not police the write-while-enabled cases; software must
	// keep the enable bits clear when changing mask or timing
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			second_own_address <= `IAT_SECOND_OWN_ADDRESS_RST;
			bus_timing_config <= `IAT_TIMING_RST;
			ctrl <= 2'h0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
			`IAT_OFF_SECOND_OWN_ADDRESS: begin
				second_own_address <= reg_wdata_i & `IAT_SECOND_OWN_ADDRESS_WMASK;
			end
			`IAT_OFF_TIMING: begin
				bus_timing_config <= reg_wdata_i & `IAT_TIMING_WMASK;
			end
			`IAT_OFF_CTRL: begin
				ctrl <= reg_wdata_i[1:0];
			end
			default: begin
				ctrl <= ctrl;
			end
			endcase
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	// unmapped offsets read as zero
	function [31:0] read_word;
		input [7:0] a;
		begin
			case (a)
			`IAT_OFF_SECOND_OWN_ADDRESS: read_word = second_own_address;
			`IAT_OFF_TIMING: read_word = bus_timing_config;
			`IAT_OFF_CTRL: read_word = {30'h0, ctrl};
			`IAT_OFF_STAT: read_word = {16'h0, cycles_done, 5'h0, state};
			default: read_word = 32'h00000000;
			endcase
		end
	endfunction

	// read data stand for one cycle only, zero otherwise
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= read_word(reg_addr_i);
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

	// ************************************************************
	// address matching
	// ************************************************************
	function [6:0] mask_of;
		input [2:0] code;
		begin
			mask_of = 7'h7f << code;
		end
	endfunction

	// reserved: 0000xxx and 1111xxx
	function is_reserved;
		input [6:0] a;
		begin
			is_reserved = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
		end
	endfunction

	wire [6:0] own7 = second_own_address[`IAT_F_ADDR_HI:`IAT_F_ADDR_LO];
	wire [6:0] cmp_mask = mask_of(second_address_mask);
	wire raw_hit = (second_address_mask == 3'h7) ||
		(((rx_addr_i ^ own7) & cmp_mask) == 7'h00);
	wire hit = raw_hit &&
		!((second_address_mask != 3'h0) && is_reserved(rx_addr_i));

	reg next_match_valid;
	reg next_match;
	reg next_ack;

	always @* begin
		next_match_valid = addr_valid_i && peripheral_enable;
		next_match = next_match_valid && hit;
		// enable bit clear still matches but answers with a nack
		next_ack = next_match && second_address_enable;
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			match_valid_o <= 1'b0;
			match_o <= 1'b0;
			ack_o <= 1'b0;
		end else begin
			match_valid_o <= next_match_valid;
			match_o <= next_match;
			ack_o <= next_ack;
		end
	end

	// ************************************************************
	// timing generator
	// ************************************************************
	wire tick;
	iat_tick #(
		.W(4)
	) u_tick (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.run_i(peripheral_enable),
		.div_i(timing_prescaler),
		.tick_o(tick)
	);

	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_LOW = 3'b010;
	localparam [2:0] S_HIGH = 3'b100;
	reg [7:0] low_cnt;
	reg [7:0] high_cnt;
	reg [3:0] hold_cnt;
	reg [3:0] setup_cnt;
	reg sda_changed;
	reg enter_low;
	reg [2:0] next_state;
	reg [7:0] next_low_cnt;
	reg [7:0] next_high_cnt;
	reg [3:0] next_hold_cnt;
	reg [3:0] next_setup_cnt;
	reg next_sda_changed;
	reg next_scl_oe;
	reg next_sda_oe;
	reg next_bit_done;
	reg [7:0] next_cycles_done;
	wire run = peripheral_enable && ctrl[`IAT_CTRL_RUN];

	// ************************************************************
	// timing next state
	// ************************************************************
	// low phase: hold count ticks then drive sda, then setup+1 ticks until
	// rise; scl low ends when both scl_low_count+1 and setup are satisfied
	always @* begin
		next_state = state;
		next_low_cnt = low_cnt;
		next_high_cnt = high_cnt;
		next_hold_cnt = hold_cnt;
		next_setup_cnt = setup_cnt;
		next_sda_changed = sda_changed;
		next_scl_oe = scl_oe_o;
		next_sda_oe = sda_oe_o;
		next_bit_done = 1'b0;
		next_cycles_done = cycles_done;
		enter_low = 1'b0;
		case (state)
		S_IDLE: begin
			enter_low = run && tick;
		end
		S_LOW: begin
			if (tick) begin
				if (!sda_changed) begin
					// the tick that empties the hold count moves sda, so a
					// hold of n gives exactly n ticks after the fall
					if (hold_cnt <= 4'h1) begin
						next_sda_oe = !tx_bit_i;
						next_sda_changed = 1'b1;
					end else begin
						next_hold_cnt = hold_cnt - 4'h1;
					end
				end else if (setup_cnt != 4'h0) begin
					next_setup_cnt = setup_cnt - 4'h1;
				end
				if (low_cnt != 8'h00) begin
					next_low_cnt = low_cnt - 8'h01;
				end else if (sda_changed && setup_cnt == 4'h0) begin
					next_state = S_HIGH;
					next_scl_oe = 1'b0;
					next_high_cnt = scl_high_count;
				end
			end
		end
		S_HIGH: begin
			// clock stretching: count only once scl really is high
			if (tick && scl_i) begin
				if (high_cnt != 8'h00) begin
					next_high_cnt = high_cnt - 8'h01;
				end else begin
					next_bit_done = 1'b1;
					next_cycles_done = cycles_done + 8'h01;
					next_state = S_IDLE;
					next_scl_oe = 1'b0;
					enter_low = run;
				end
			end
		end
		default: begin
			next_state = S_IDLE;
		end
		endcase
		// every low phase starts here, from idle or straight after a high
		if (enter_low) begin
			next_state = S_LOW;
			next_scl_oe = 1'b1;
			next_low_cnt = scl_low_count;
			next_hold_cnt = data_hold_count;
			next_setup_cnt = data_setup_count;
			next_sda_changed = 1'b0;
			// zero hold: sda moves on the same edge that pulls scl low
			if (data_hold_count == 4'h0) begin
				next_sda_oe = !tx_bit_i;
				next_sda_changed = 1'b1;
			end
		end
	end

	// ************************************************************
	// timing registers
	// ************************************************************
	// clearing the peripheral enable drops the bus and all phase state
	always @(posedge mclk_i) begin
		if (!rst_n_i || !peripheral_enable) begin
			state <= S_IDLE;
			scl_oe_o <= 1'b0;
		end else begin
			state <= next_state;
			scl_oe_o <= next_scl_oe;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i || !peripheral_enable) begin
			low_cnt <= 8'h00;
			high_cnt <= 8'h00;
			hold_cnt <= 4'h0;
			setup_cnt <= 4'h0;
		end else begin
			low_cnt <= next_low_cnt;
			high_cnt <= next_high_cnt;
			hold_cnt <= next_hold_cnt;
			setup_cnt <= next_setup_cnt;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i || !peripheral_enable) begin
			sda_changed <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			sda_changed <= next_sda_changed;
			sda_oe_o <= next_sda_oe;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i || !peripheral_enable) begin
			bit_done_o <= 1'b0;
			cycles_done <= 8'h00;
		end else begin
			bit_done_o <= next_bit_done;
			cycles_done <= next_cycles_done;
		end
	end

	// ************************************************************
	// pin outputs
	// ************************************************************
	// open drain: the data side of each pad stays low, only enables move
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			peripheral_enable_o <= 1'b0;
		end else begin
			peripheral_enable_o <= peripheral_enable;
		end
	end
	wire unused_sda = sda_i;
endmodule // iat_core
`default_nettype wire

// ===== rtl/iat_map.vh
// register offsets, field positions and reset values of the address-match and timing block
// What this block does
// - compare received 7-bit address with second own address bits 7:1; bit 0 ignored
// - mask field bits 10:8; 000 full compare, 001-110 ignore one to six low bits
// - mask code 111 skips comparison and matches every non-reserved 7-bit address
// - with nonzero mask, reserved addresses never match the second own address
// - enable bit 15: clear answers NACK on match, set answers ACK
// - kernel clock divided by prescaler bits 31:28 plus one gives timing tick
// - SCL low lasts low count bits 7:0 plus one ticks, or hold plus setup plus one ticks if that is longer; also bus free time
// - SCL high lasts high count bits 15:8 plus one ticks; also start hold
// - SDA changes after SCL fall by hold count bits 19:16 ticks, no plus one
// - setup count bits 23:20 plus one ticks from SDA change to SCL rise
`ifndef IAT_MAP_VH
`define IAT_MAP_VH
`define IAT_OFF_SECOND_OWN_ADDRESS 8'h0c
`define IAT_OFF_TIMING 8'h10
`define IAT_OFF_CTRL 8'h20
`define IAT_OFF_STAT 8'h24
`define IAT_SECOND_OWN_ADDRESS_RST 32'h00000000
`define IAT_SECOND_OWN_ADDRESS_WMASK 32'h000087fe
`define IAT_TIMING_RST 32'h00000000
`define IAT_TIMING_WMASK 32'hf0ffffff
`define IAT_F_ADDR_HI 7
`define IAT_F_ADDR_LO 1
`define IAT_F_MSK_HI 10
`define IAT_F_MSK_LO 8
`define IAT_F_EN 15
`define IAT_F_SCL_LOW_COUNT_HI 7
`define IAT_F_SCL_LOW_COUNT_LO 0
`define IAT_F_SCL_HIGH_COUNT_HI 15
`define IAT_F_SCL_HIGH_COUNT_LO 8
`define IAT_F_HOLD_HI 19
`define IAT_F_HOLD_LO 16
`define IAT_F_SETUP_HI 23
`define IAT_F_SETUP_LO 20
`define IAT_F_PSC_HI 31
`define IAT_F_PSC_LO 28
`define IAT_CTRL_PE 0
`define IAT_CTRL_RUN 1
`endif

// ===== rtl/iat_tick.v
// prescaler that turns the kernel clock into timing ticks
`timescale 1ns/1ps
`default_nettype none
module iat_tick #(
	parameter W = 4
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_n_i,
	// control
	input wire run_i,
	input wire [W-1:0] div_i,
	// tick out
	output reg tick_o
);
	reg [W-1:0] cnt;
	// one tick every div_i+1 kernel clocks
	always @(posedge mclk_i) begin
		if (!rst_n_i || !run_i) begin
			cnt <= {W{1'b0}};
			tick_o <= 1'b0;
		end else if (cnt == div_i) begin
			cnt <= {W{1'b0}};
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end
endmodule // iat_tick
`default_nettype wire

// ===== verification/iat_bus_model.sv
// far side of the bus: pull-ups, wired-and and a slow device
`timescale 1ns/1ps
`default_nettype none
module iat_bus_model (
	input wire logic mclk_i,
	input wire logic scl_oe_i,
	input wire logic sda_oe_i,
	input wire logic [3:0] stretch_i,
	output logic scl_o,
	output logic sda_o
);
	logic [3:0] hold = 4'h0;
	// a slow device keeps scl low a few cycles after the master lets go
	always @(posedge mclk_i)
		hold <= scl_oe_i ? stretch_i : hold - (hold != 4'h0);
	assign scl_o = !scl_oe_i && hold == 4'h0;
	assign sda_o = !sda_oe_i;
endmodule // iat_bus_model
`default_nettype wire

// ===== verification/iat_core_bench.sv
// self-checking bench for the address matcher and bus timing
`timescale 1ns/1ps
`default_nettype none
module iat_core_bench;
	logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, tx_bit_i = 0;
	logic addr_valid_i = 0;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0, v = 32'hffffffff;
	logic [6:0] rx_addr_i = 7'h0;
	logic [3:0] stretch = 4'h0;
	wire logic [31:0] reg_rdata_o;
	wire logic match_valid_o, match_o, ack_o, scl_oe_o, sda_oe_o, scl, sda;
	wire logic bit_done, scl_out, sda_out, pe_out;
	int fail_count = 0, n_checks = 0, cyc = 0;
	iat_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .addr_valid_i(addr_valid_i),
		.rx_addr_i(rx_addr_i), .match_valid_o(match_valid_o),
		.match_o(match_o), .ack_o(ack_o), .tx_bit_i(tx_bit_i), .scl_i(scl),
		.scl_o(scl_out), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_out),
		.sda_oe_o(sda_oe_o), .peripheral_enable_o(pe_out),
		.bit_done_o(bit_done));
	iat_bus_model far (.mclk_i(mclk_i), .scl_oe_i(scl_oe_o),
		.sda_oe_i(sda_oe_o), .stretch_i(stretch), .scl_o(scl), .sda_o(sda));
	initial forever #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task conclude;
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 0;
	endtask
	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		reg_rd_i <= 1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 0;
		#1 chk(nm, reg_rdata_o, e);
	endtask
	// 0 watches scl drive, 1 sda drive, 2 the bus clock line
	task wait_lvl(input int s, input logic l, output int n);
		#1 n = 0;
		while ((s == 0 ? scl_oe_o : s == 1 ? sda_oe_o : scl) !== l && n < 999)
		begin
			@(posedge mclk_i);
			#1 n++;
		end
	endtask
	task t_regs;
		rd_chk("timing rst", 8'h10, 32'h0);
		chk("scl out", scl_out, 0);
		chk("sda out", sda_out, 0);
		wr(8'h0c, 32'hffffffff);
		wr(8'h10, 32'hffffffff);
		rd_chk("second_own_address", 8'h0c, 32'h000087fe);
		rd_chk("timing", 8'h10, 32'hf0ffffff);
		rd_chk("unmapped", 8'h04, 32'h0);
	endtask
	task t_match;
		logic m;
		for (int e = 0; e < 2; e++)
			for (int c = 0; c < 8; c++) begin
				wr(8'h0c, v & 32'h7fff);
				v = {16'h0, e[0], 4'h0, c[2:0], 8'hb4};
				wr(8'h0c, v & 32'h7fff);
				wr(8'h0c, v);
				for (int a = 0; a < 128; a++) begin
					@(posedge mclk_i);
					addr_valid_i <= 1;
					rx_addr_i <= a[6:0];
					@(posedge mclk_i);
					addr_valid_i <= 0;
					m = ((a ^ 7'h5a) >> c) == 0;
					m = m && (c == 0 || !(a[6:3] inside {0, 15}));
					#1 chk("valid", match_valid_o, 1);
					chk("match", match_o, m);
					chk("ack", ack_o, m && e);
				end
			end
	endtask
	task t_timing;
		int n;
		wr(8'h20, 32'h0);
		wr(8'h10, 32'h10120201);
		stretch <= 4'h3;
		wr(8'h20, 32'h3);
		wait_lvl(0, 1, n);
		wait_lvl(1, 1, n);
		chk("hold", n inside {[3:5]}, 1);
		wait_lvl(0, 0, n);
		chk("setup", n inside {[3:5]}, 1);
		tx_bit_i <= 1;
		wait_lvl(2, 1, n);
		wait_lvl(2, 0, n);
		chk("high", n inside {[5:7]}, 1);
		chk("bit done", bit_done, 1);
		wait_lvl(1, 0, n);
		chk("enable out", pe_out, 1);
		rd_chk("ctrl", 8'h20, 32'h3);
		wr(8'h20, 32'h0);
		wr(8'h10, 32'h00010007);
		wr(8'h20, 32'h3);
		wait_lvl(0, 1, n);
		wait_lvl(0, 0, n);
		chk("low", n inside {[7:9]}, 1);
	endtask
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1;
		t_regs();
		wr(8'h20, 32'h1);
		t_match();
		t_timing();
		conclude();
	end
endmodule // iat_core_bench
`default_nettype wire

// ===== verification/iat_props.sv
// concurrent checks on the matcher and timing ports
`timescale 1ns/1ps
`default_nettype none
module iat_props (
	// watched ports
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic addr_valid_i,
	input wire logic [6:0] rx_addr_i,
	input wire logic match_valid_o,
	input wire logic match_o,
	input wire logic ack_o,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o,
	input wire logic peripheral_enable_o
);
	// shadows follow bus writes only; a second reset does not clear them
	logic [31:0] a2 = 32'h0, tm = 32'h0;
	logic [15:0] cnt = 16'h0;
	always @(posedge mclk_i) begin
		if (reg_wr_i && reg_addr_i == 8'h0c)
			a2 <= reg_wdata_i;
		if (reg_wr_i && reg_addr_i == 8'h10)
			tm <= reg_wdata_i;
		cnt <= $changed(scl_oe_o) ? 16'h1 : cnt + 16'h1;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_addr_cmp: assert property (
		match_valid_o |-> match_o == (((($past(rx_addr_i) ^ $past(a2[7:1]))
		>> $past(a2[10:8])) == 7'h0) && ($past(a2[10:8]) == 3'h0
		|| !($past(rx_addr_i[6:3]) inside {4'h0, 4'hf}))))
		else $error("address match wrong");
	a_ack_enable: assert property (
		match_valid_o |-> ack_o == (match_o && $past(a2[15])))
		else $error("ack vs enable");
	a_ack_match: assert property (ack_o |-> match_o)
		else $error("ack without match");
	a_match_answer: assert property (
		addr_valid_i && peripheral_enable_o |=> match_valid_o)
		else $error("no match answer");
	a_valid_cause: assert property (match_valid_o |-> $past(addr_valid_i))
		else $error("spurious match answer");
	a_sda_steady: assert property (
		!scl_oe_o && !$past(scl_oe_o) |-> $stable(sda_oe_o))
		else $error("sda moved while scl released");
	a_scl_low_min: assert property (
		$fell(scl_oe_o) |-> cnt >= tm[7:0] * (tm[31:28] + 1) + 1)
		else $error("scl low too short");
	a_scl_high_min: assert property (
		$rose(scl_oe_o) |-> cnt >= tm[15:8] * (tm[31:28] + 1) + 1)
		else $error("scl high too short");
endmodule // iat_props
bind iat_core iat_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.addr_valid_i(addr_valid_i), .rx_addr_i(rx_addr_i),
	.match_valid_o(match_valid_o), .match_o(match_o), .ack_o(ack_o),
	.scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
	.peripheral_enable_o(peripheral_enable_o));
`default_nettype wire
